// file: rtl/umc_defines.svh
// Offsets, field positions, reset values and timing counts of the modem outputs.
`ifndef UMC_DEFINES_SVH
`define UMC_DEFINES_SVH
`define UMC_OFF_MCR1 3'h0
`define UMC_OFF_MCR2 3'h1
`define UMC_OFF_STATUS 3'h2
`define UMC_OFF_IDX_BASE 3'h3
`define UMC_OFF_SERIO 3'h4
`define UMC_MCR_DTR_BIT 0
`define UMC_MCR_RTS_BIT 1
`define UMC_MCR_LOOP_BIT 4
`define UMC_MCR_RESET 8'h00
`define UMC_BASE_STRAP_LO 16'h03F0
`define UMC_BASE_STRAP_HI 16'h0370
`define UMC_SETTLE_CYCLES 2'h2
`endif

// file: rtl/umc_modem_outputs.sv
// Modem handshake outputs for two serial ports and the base-select strap.
`timescale 1ns/1ps
`include "umc_defines.svh"
module umc_modem_outputs (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	// Register port
	input wire logic [2:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	// Port one modem pins
	output logic PORT1_SEND_REQUEST_N_O,
	output logic PORT1_TERMINAL_READY_N_O,
	// Port two modem pins, send request is two-way for the strap
	input wire logic PORT2_SEND_REQUEST_N_I,
	output logic PORT2_SEND_REQUEST_N_O,
	output logic PORT2_SEND_REQUEST_N_OE_O,
	output logic PORT2_TERMINAL_READY_N_O,
	// Serial data, port two shared with infrared
	input wire logic PORT1_SERIAL_IN_I,
	input wire logic PORT2_SERIAL_IN_IR_IN_I,
	input wire logic PORT1_UART_TX_I,
	input wire logic PORT2_UART_TX_I,
	input wire logic PORT2_IR_TX_I,
	output logic PORT1_SERIAL_OUT_O,
	output logic PORT2_SERIAL_OUT_IR_OUT_O,
	output logic PORT1_UART_RX_O,
	output logic PORT2_UART_RX_O,
	output logic PORT2_IR_RX_O,
	// Configuration decode
	output logic CONFIG_BASE_STRAP_O,
	output logic [15:0] INDEX_BASE_O
);
	logic [7:0] mcr1_r, mcr1_nxt;
	logic [7:0] mcr2_r, mcr2_nxt;
	logic ir_sel_r, ir_sel_nxt;
	logic strap_r, strap_nxt;
	logic [1:0] settle_r, settle_nxt;
	umc_pkg::umc_phase_type phase_r, phase_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	umc_pkg::umc_bus_type bus;
	umc_pkg::umc_modem_type m1_nxt, m2_nxt, m1_r, m2_r;

	assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	// The settle counter is two bits wide, so the count must fit in it.
	if (`UMC_SETTLE_CYCLES < 1 || `UMC_SETTLE_CYCLES > 3) begin : g_settle_check
		$error("Settle count must lie between one and three.");
	end

	// Register writes and read data.
	always_comb begin
		mcr1_nxt = mcr1_r;
		mcr2_nxt = mcr2_r;
		ir_sel_nxt = ir_sel_r;
		rdata_nxt = 8'h00;
		if (bus.wr) begin
			case (bus.addr)
				`UMC_OFF_MCR1: mcr1_nxt = bus.wdata;
				`UMC_OFF_MCR2: mcr2_nxt = bus.wdata;
				`UMC_OFF_SERIO: ir_sel_nxt = bus.wdata[0];
				default: ;
			endcase
		end
		if (bus.rd) begin
			case (bus.addr)
				`UMC_OFF_MCR1: rdata_nxt = mcr1_r;
				`UMC_OFF_MCR2: rdata_nxt = mcr2_r;
				`UMC_OFF_STATUS: rdata_nxt = {4'h0,
					phase_r == umc_pkg::ST_RUN, strap_r,
					m2_r.send_request_n, m1_r.send_request_n};
				`UMC_OFF_IDX_BASE: rdata_nxt = INDEX_BASE_O[7:0];
				`UMC_OFF_SERIO: rdata_nxt = {7'h00, ir_sel_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Strap capture: the first edge after release samples the pin, which
	// the board holds steady, before the pin is turned into an output.
	always_comb begin
		phase_nxt = phase_r;
		strap_nxt = strap_r;
		settle_nxt = settle_r;
		case (phase_r)
			umc_pkg::ST_RESET: begin
				strap_nxt = PORT2_SEND_REQUEST_N_I;
				phase_nxt = umc_pkg::ST_SETTLE;
				settle_nxt = 2'h0;
			end
			umc_pkg::ST_SETTLE: begin
				settle_nxt = settle_r + 2'h1;
				if (settle_r == `UMC_SETTLE_CYCLES - 2'h1) begin
					phase_nxt = umc_pkg::ST_RUN;
				end
			end
			umc_pkg::ST_RUN: ;
			default: phase_nxt = umc_pkg::ST_RESET;
		endcase
	end

	// Modem outputs: inactive high in loop mode, else the inverted bits.
	always_comb begin
		m1_nxt.send_request_n = mcr1_r[`UMC_MCR_LOOP_BIT] |
			~mcr1_r[`UMC_MCR_RTS_BIT];
		m1_nxt.terminal_ready_n = mcr1_r[`UMC_MCR_LOOP_BIT] |
			~mcr1_r[`UMC_MCR_DTR_BIT];
		m2_nxt.send_request_n = mcr2_r[`UMC_MCR_LOOP_BIT] |
			~mcr2_r[`UMC_MCR_RTS_BIT];
		m2_nxt.terminal_ready_n = mcr2_r[`UMC_MCR_LOOP_BIT] |
			~mcr2_r[`UMC_MCR_DTR_BIT];
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mcr1_r <= `UMC_MCR_RESET;
			mcr2_r <= `UMC_MCR_RESET;
			ir_sel_r <= 1'b0;
			rdata_r <= 8'h00;
			phase_r <= umc_pkg::ST_RESET;
			strap_r <= 1'b0;
			settle_r <= 2'h0;
			m1_r <= 2'b11;
			m2_r <= 2'b11;
		end else begin
			mcr1_r <= mcr1_nxt;
			mcr2_r <= mcr2_nxt;
			ir_sel_r <= ir_sel_nxt;
			rdata_r <= rdata_nxt;
			phase_r <= phase_nxt;
			strap_r <= strap_nxt;
			settle_r <= settle_nxt;
			m1_r <= m1_nxt;
			m2_r <= m2_nxt;
		end
	end

	assign RDATA_O = rdata_r;
	assign PORT1_SEND_REQUEST_N_O = m1_r.send_request_n;
	assign PORT1_TERMINAL_READY_N_O = m1_r.terminal_ready_n;
	assign PORT2_TERMINAL_READY_N_O = m2_r.terminal_ready_n;
	// The pin is driven only in the run phase so that a pull strap is not fought.
	assign PORT2_SEND_REQUEST_N_O = m2_r.send_request_n;
	assign PORT2_SEND_REQUEST_N_OE_O = (phase_r == umc_pkg::ST_RUN);
	assign CONFIG_BASE_STRAP_O = strap_r;
	assign INDEX_BASE_O = strap_r ? `UMC_BASE_STRAP_HI :
		`UMC_BASE_STRAP_LO;

	// Port two pins serve either the UART or the infrared path.
	assign PORT1_SERIAL_OUT_O = PORT1_UART_TX_I;
	assign PORT1_UART_RX_O = PORT1_SERIAL_IN_I;
	assign PORT2_SERIAL_OUT_IR_OUT_O = ir_sel_r ? PORT2_IR_TX_I :
		PORT2_UART_TX_I;
	assign PORT2_UART_RX_O = ir_sel_r ? 1'b1 : PORT2_SERIAL_IN_IR_IN_I;
	assign PORT2_IR_RX_O = ir_sel_r ? PORT2_SERIAL_IN_IR_IN_I : 1'b1;

	a_rts_from_bit: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		$past(RST_N_I) |-> PORT1_SEND_REQUEST_N_O ==
		($past(mcr1_r[`UMC_MCR_LOOP_BIT]) | ~$past(mcr1_r[`UMC_MCR_RTS_BIT])))
		else $error("Port one send request does not follow control bit.");
	a_dtr_from_bit: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		$past(RST_N_I) |-> PORT2_TERMINAL_READY_N_O ==
		($past(mcr2_r[`UMC_MCR_LOOP_BIT]) | ~$past(mcr2_r[`UMC_MCR_DTR_BIT])))
		else $error("Port two terminal ready does not follow control bit.");
	a_loop_forces_high: assert property (@(posedge SYS_CLK_I)
		disable iff (!RST_N_I) mcr1_r[`UMC_MCR_LOOP_BIT] |=> PORT1_SEND_REQUEST_N_O
		&& PORT1_TERMINAL_READY_N_O)
		else $error("Loop mode left a port one output active.");
	a_reset_rts_high: assert property (@(posedge SYS_CLK_I)
		$rose(RST_N_I) |-> PORT1_SEND_REQUEST_N_O && PORT2_SEND_REQUEST_N_O)
		else $error("Send request not high after reset.");
	a_reset_dtr_high: assert property (@(posedge SYS_CLK_I)
		$rose(RST_N_I) |-> PORT1_TERMINAL_READY_N_O && PORT2_TERMINAL_READY_N_O)
		else $error("Terminal ready not high after reset.");
	a_strap_latched: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		phase_r == umc_pkg::ST_RESET |=> strap_r == $past(PORT2_SEND_REQUEST_N_I)
		##1 strap_r == $past(strap_r))
		else $error("Strap not latched from the pin at release.");
	a_index_base: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		INDEX_BASE_O == (strap_r ? 16'h0370 : 16'h03F0))
		else $error("Index base does not match the strap.");

	// The pin stays released through the capture and settle cycles.
	sequence s_pin_held;
		!PORT2_SEND_REQUEST_N_OE_O [*3];
	endsequence

	sequence s_pin_driven;
		PORT2_SEND_REQUEST_N_OE_O;
	endsequence

	a_pin_released: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		phase_r == umc_pkg::ST_RESET |-> s_pin_held ##1 s_pin_driven)
		else $error("Port two send pin driven before strap latch.");

	a_ir_share: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		ir_sel_r |-> PORT2_SERIAL_OUT_IR_OUT_O == PORT2_IR_TX_I)
		else $error("Infrared transmit not on shared port two pin.");

	// Second port and remaining output of each port follow their bits too.
	a_rts2_from_bit: assert property (@(posedge SYS_CLK_I)
		disable iff (!RST_N_I)
		$past(RST_N_I) |-> PORT2_SEND_REQUEST_N_O ==
		($past(mcr2_r[`UMC_MCR_LOOP_BIT]) | ~$past(mcr2_r[`UMC_MCR_RTS_BIT])))
		else $error("Port two send request does not follow control bit.");

	a_dtr1_from_bit: assert property (@(posedge SYS_CLK_I)
		disable iff (!RST_N_I)
		$past(RST_N_I) |-> PORT1_TERMINAL_READY_N_O ==
		($past(mcr1_r[`UMC_MCR_LOOP_BIT]) | ~$past(mcr1_r[`UMC_MCR_DTR_BIT])))
		else $error("Port one terminal ready does not follow control bit.");

	a_loop2_forces_high: assert property (@(posedge SYS_CLK_I)
		disable iff (!RST_N_I)
		mcr2_r[`UMC_MCR_LOOP_BIT] |=> PORT2_SEND_REQUEST_N_O &&
		PORT2_TERMINAL_READY_N_O)
		else $error("Loop mode left a port two output active.");

	// Control register writes land on the next edge.
	a_mcr1_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		WR_I && ADDR_I == `UMC_OFF_MCR1 |=> mcr1_r == $past(WDATA_I))
		else $error("Port one control write did not land.");

	a_mcr2_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		WR_I && ADDR_I == `UMC_OFF_MCR2 |=> mcr2_r == $past(WDATA_I))
		else $error("Port two control write did not land.");

	a_serio_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		WR_I && ADDR_I == `UMC_OFF_SERIO |=> ir_sel_r == $past(WDATA_I[0]))
		else $error("Infrared select write did not land.");

	// Read data stand for one cycle only and are zero otherwise.
	a_mcr1_read: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		RD_I && ADDR_I == `UMC_OFF_MCR1 |=> RDATA_O == $past(mcr1_r))
		else $error("Port one control read returned wrong data.");

	a_mcr2_read: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		RD_I && ADDR_I == `UMC_OFF_MCR2 |=> RDATA_O == $past(mcr2_r))
		else $error("Port two control read returned wrong data.");

	a_status_strap: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		RD_I && ADDR_I == `UMC_OFF_STATUS |=> RDATA_O[2] == $past(strap_r))
		else $error("Status read does not show the strap.");

	a_rdata_idle: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		$past(RST_N_I) && !$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("Read data not zero outside a read answer.");

	// Strap after the capture, and pin drive in reset and after the capture.
	a_strap_steady: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		phase_r == umc_pkg::ST_RUN |=> $stable(strap_r))
		else $error("Strap changed after it was latched.");

	a_oe_in_reset: assert property (@(posedge SYS_CLK_I)
		!RST_N_I |-> !PORT2_SEND_REQUEST_N_OE_O)
		else $error("Port two send pin driven during reset.");

	a_oe_stays_on: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		PORT2_SEND_REQUEST_N_OE_O |=> PORT2_SEND_REQUEST_N_OE_O)
		else $error("Port two send pin released while running.");

	// Serial routing of the shared port two pins and the port one pass-through.
	a_ir_rx_route: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		ir_sel_r |-> PORT2_IR_RX_O == PORT2_SERIAL_IN_IR_IN_I &&
		PORT2_UART_RX_O)
		else $error("Infrared receive not routed from shared pin.");

	a_uart_route: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		!ir_sel_r |-> PORT2_SERIAL_OUT_IR_OUT_O == PORT2_UART_TX_I &&
		PORT2_UART_RX_O == PORT2_SERIAL_IN_IR_IN_I && PORT2_IR_RX_O)
		else $error("Serial path not routed on shared pins.");

	a_port1_route: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		PORT1_SERIAL_OUT_O == PORT1_UART_TX_I &&
		PORT1_UART_RX_O == PORT1_SERIAL_IN_I)
		else $error("Port one serial pins not passed through.");
endmodule // umc_modem_outputs

// file: rtl/umc_pkg.sv
// Types shared by the modem output block.
package umc_pkg;
	typedef enum logic [1:0] {
		ST_RESET,
		ST_SETTLE,
		ST_RUN
	} umc_phase_type;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} umc_bus_type;
	typedef struct packed {
		logic send_request_n;
		logic terminal_ready_n;
	} umc_modem_type;
endpackage

// file: verification/tb_uart_modem_control_outputs.sv
// Self-checking bench for modem outputs, strap and serial sharing.
`timescale 1ns/1ps
`include "umc_defines.svh"
module tb_uart_modem_control_outputs;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, strap = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, rdata, m1, m2, d;
	logic [4:0] sin = 5'h00;
	logic s1, t1, p2, s2, oe, t2, so1, so2, ur1, ur2, irr, cs, a, sel;
	logic [15:0] base;
	int n_fail = 0, total_checks = 0;
	umc_modem_outputs umc_modem_outputs_inst (.SYS_CLK_I(clk),
		.RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .PORT1_SEND_REQUEST_N_O(s1),
		.PORT1_TERMINAL_READY_N_O(t1), .PORT2_SEND_REQUEST_N_I(p2),
		.PORT2_SEND_REQUEST_N_O(s2), .PORT2_SEND_REQUEST_N_OE_O(oe),
		.PORT2_TERMINAL_READY_N_O(t2), .PORT1_SERIAL_IN_I(sin[0]),
		.PORT2_SERIAL_IN_IR_IN_I(sin[1]), .PORT1_UART_TX_I(sin[2]),
		.PORT2_UART_TX_I(sin[3]), .PORT2_IR_TX_I(sin[4]),
		.PORT1_SERIAL_OUT_O(so1), .PORT2_SERIAL_OUT_IR_OUT_O(so2),
		.PORT1_UART_RX_O(ur1), .PORT2_UART_RX_O(ur2), .PORT2_IR_RX_O(irr),
		.CONFIG_BASE_STRAP_O(cs), .INDEX_BASE_O(base));
	umc_modem_far_end umc_modem_far_end_inst (.strap_i(strap), .drv_i(s2),
		.oe_i(oe), .pin_o(p2));
	initial begin
		forever #10 clk = ~clk;
	end
	function automatic logic [1:0] exp_pins(input logic [7:0] m);
		return m[`UMC_MCR_LOOP_BIT] ? 2'b11 :
			{~m[`UMC_MCR_RTS_BIT], ~m[`UMC_MCR_DTR_BIT]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic wr_reg(input logic [2:0] ad, input logic [7:0] dt);
		@(posedge clk);
		wr <= 1'b1;
		addr <= ad;
		wdata <= dt;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] ad, input logic [7:0] ex);
		@(posedge clk);
		rd <= 1'b1;
		addr <= ad;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, ex);
	endtask
	task automatic do_reset(input logic st);
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= st;
		repeat (3) @(posedge clk);
		#1 chk({s1, s2, t1, t2, oe}, 5'h1E);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(oe, 1'b0);
		@(posedge clk);
		#1 chk(oe, 1'b1);
		chk(cs, st);
		chk(base, st ? `UMC_BASE_STRAP_HI : `UMC_BASE_STRAP_LO);
		m1 = 8'h00;
		m2 = 8'h00;
	endtask
	initial begin
		#100000;
		n_fail++;
		wrap_up();
	end
	initial begin
		m1 = 8'($urandom(80833));
		do_reset(1'b0);
		for (int i = 0; i < 40; i++) begin
			a = 1'($urandom);
			d = (i < 4) ? 8'h01 << i : 8'($urandom) & 8'h13;
			sel = 1'($urandom);
			wr_reg({2'h0, a}, d);
			sin <= 5'($urandom);
			if (a) m2 = d;
			else m1 = d;
			wr_reg(`UMC_OFF_SERIO, {7'h00, sel});
			#1 chk({s1, t1, s2, t2}, {exp_pins(m1), exp_pins(m2)});
			chk({so1, so2, ur1, ur2, irr}, {sin[2], sel ? sin[4] : sin[3],
				sin[0], sel ? 1'b1 : sin[1], sel ? sin[1] : 1'b1});
			rd_reg({2'h0, a}, d);
		end
		rd_reg(3'h5, 8'h00);
		wr_reg(`UMC_OFF_MCR1, 8'h03);
		wr_reg(`UMC_OFF_MCR2, 8'h03);
		do_reset(1'b1);
		chk({s1, t1, s2, t2}, 4'hF);
		rd_reg(`UMC_OFF_IDX_BASE, 8'h70);
		rd_reg(`UMC_OFF_STATUS, 8'h0F);
		wrap_up();
	end
endmodule // tb_uart_modem_control_outputs

// file: verification/umc_modem_far_end.sv
// Far-side model: board strap and the resolved port two send pin.
`timescale 1ns/1ps
module umc_modem_far_end (
	// Strap level and device drive
	input wire logic strap_i,
	input wire logic drv_i,
	input wire logic oe_i,
	// Resolved pin level
	output logic pin_o
);
	// The strap resistor sets the pin while the device does not drive.
	assign pin_o = oe_i ? drv_i : strap_i;
endmodule // umc_modem_far_end
